// file: btc_pkg.sv
// Constants and encodings shared by the transient classifier front end
package btc_pkg;
    // Register byte offsets on the APB
    localparam logic [11:0] BTC_CTRL_OFS = 12'h000;
    localparam logic [11:0] BTC_SHARP_OFS = 12'h004;
    localparam logic [11:0] BTC_FB_LO_OFS = 12'h008;
    localparam logic [11:0] BTC_FB_HI_OFS = 12'h00C;
    localparam logic [11:0] BTC_STATUS_OFS = 12'h010;
    localparam logic [11:0] BTC_LTE_OFS = 12'h014;
    localparam logic [11:0] BTC_TILT_OFS = 12'h018;
    // CTRL fields
    localparam int BTC_CTRL_SWB = 0;
    localparam int BTC_CTRL_INACTIVE = 1;
    localparam int BTC_CTRL_FB = 2;
    localparam int BTC_CTRL_WB = 3;
    localparam int BTC_CTRL_CORE_LSB = 4;
    localparam int BTC_CTRL_CORE_W = 4;
    localparam logic [31:0] BTC_CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] BTC_CTRL_MASK = 32'h0000_00FF;
    // SHARP fields: value, high threshold, low threshold
    localparam int BTC_SHARP_VAL_LSB = 0;
    localparam int BTC_SHARP_HI_LSB = 8;
    localparam int BTC_SHARP_LO_LSB = 16;
    localparam logic [31:0] BTC_SHARP_RESET = 32'h0004_1000;
    // STATUS fields
    localparam int BTC_ST_CLASS_LSB = 0;
    localparam int BTC_ST_HB = 2;
    localparam int BTC_ST_LB = 3;
    localparam int BTC_ST_HANG = 4;
    localparam int BTC_ST_ENVB_LSB = 5;
    localparam int BTC_ST_NSPEC_LSB = 10;
    localparam int BTC_ST_NTIME_LSB = 14;
    localparam int BTC_ST_FBQ_LSB = 17;
    localparam int BTC_ST_BUSY = 21;
    localparam int BTC_ST_TILT = 22;
    localparam int BTC_ST_PREV_LSB = 23;
    localparam int BTC_ST_TOTAL_LSB = 25;
    // Per-frame budget
    localparam logic [4:0] BTC_FRAME_BITS = 5'h1F;
    localparam logic [4:0] BTC_CLASS_BITS = 5'h02;
    localparam logic [4:0] BTC_ENV_BITS = BTC_FRAME_BITS - BTC_CLASS_BITS;
    localparam logic [3:0] BTC_SPEC_TRANS = 4'h4;
    localparam logic [3:0] BTC_SPEC_STEADY = 4'hE;
    localparam logic [2:0] BTC_TIME_TRANS = 3'h4;
    localparam logic [2:0] BTC_TIME_NONE = 3'h0;
    localparam logic [3:0] BTC_FBQ_MAX = 4'hF;
    // Class codes
    localparam logic [1:0] BTC_NOISE_CLASS = 2'h0;
    localparam logic [1:0] BTC_TRANSIENT_CLASS = 2'h1;
    localparam logic [1:0] BTC_NORMAL_CLASS = 2'h2;
    localparam logic [1:0] BTC_HARMONIC_CLASS = 2'h3;
    // Frame geometry (coefficients per frame equal the samples per frame)
    localparam logic [8:0] BTC_FRAME_LEN = 9'h140;
    localparam logic [6:0] BTC_SUB_LEN = 7'h50;
    localparam logic [8:0] BTC_LB_LEN = 9'h100;
    localparam logic [5:0] BTC_LB_SUB_LAST = 6'h3F;
    // Samples of delay between core and extension paths, arbitrary default
    localparam int BTC_DELAY = 16;
    // Filter coefficients in Q15
    localparam int BTC_COEF_FRAC = 15;
    localparam logic signed [16:0] BTC_HP_POLE = 17'sh03F1E;
    localparam logic signed [16:0] BTC_HP_GAIN = 17'sh05F4F;
    // Thresholds scaled by two so that half steps stay integer
    localparam logic [55:0] BTC_RHO_INACTIVE_X2 = 56'h14;
    localparam logic [55:0] BTC_RHO_ACTIVE_X2 = 56'h1B;
    localparam logic [47:0] BTC_LB_RATIO_X2 = 48'h0B;
    // Tilt above 8 tested as squared above 64 times r0
    localparam int BTC_TILT_SHIFT = 6;
    localparam int BTC_LT_SHIFT = 2;
    // One-hot frame states
    typedef enum logic [2:0] {
        BTC_IDLE = 3'b001,
        BTC_COLLECT = 3'b010,
        BTC_DECIDE = 3'b100
    } btc_state_t;
endpackage

// file: btc_transient_classifier.sv
// Transient classifier, bit budget and transform feed for the extension encoder
// How it works
// - Every frame carries a fixed 31-bit extension budget.
// - Two of those bits carry the frame's signal class.
// - Transient frames: remaining 29 bits for four spectral, four time envelopes.
// - Other frames: fourteen spectral envelopes, no time envelope.
// - 320 high-band coefficients are coded per frame.
// - Full-band mode codes a quantised 4-bit ratio of two band energies.
// - Filtered input is delayed, positioned in the window and sent to the transform.
// - First-order high-pass: 0.4931 prior output, 0.7446 times input difference.
// - 320 filtered samples form four 80-sample sub-frames; energy is sum of squares.
// - Long-term energy: three quarters old plus one quarter sub-frame energy.
// - On algorithm or core change, seed long-term energy with first 80 samples.
// - Filter state and final long-term energy carry into the next frame.
// - Transient when sub-frame energy exceeds 10 or 13.5 times prior long-term.
// - No transient when the previous frame did not use this extension.
// - A detected transient forces a transient in the next frame too.
// - Tilt is over root r0 on 256 low-band samples.
// - Transient with tilt above 8 is cleared and hangover zeroed.
// - Low-band flag when a 64-sample energy exceeds 5.5 times the previous.
// - Transient frames take the transient class.
// - Other frames: harmonic, noise or normal by sharpness.
// - Wideband mode codes spectral envelopes only.
// - High-band path delay is core delay minus extension delay.
// - Class codes noise 00, transient 01, normal 10, harmonic 11; class kept.
module btc_transient_classifier
    import btc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_start,
    input wire logic signed [15:0] super_high_band,
    input wire logic shb_valid,
    output logic shb_ready,
    input wire logic signed [15:0] low_band,
    input wire logic lb_valid,
    output logic lb_ready,
    output logic signed [19:0] mdct_sample,
    output logic mdct_valid,
    output logic [8:0] mdct_pos,
    output logic frame_done,
    output logic [1:0] signal_class,
    output logic high_band_transient_flag,
    output logic low_band_transient_flag,
    output logic [3:0] spectral_env_count,
    output logic [2:0] time_env_count,
    output logic [3:0] fb_ratio_index
);
    typedef struct packed {
        btc_state_t st;
        logic [8:0] shb_cnt;
        logic [6:0] sub_pos;
        logic [8:0] lb_cnt;
        logic signed [19:0] hp_y;
        logic signed [15:0] hp_x;
        logic [47:0] e_acc;
        logic [47:0] lt;
        logic lt_reset;
        logic det;
        logic hang;
        logic [47:0] elf_acc;
        logic [47:0] elf_prev;
        logic lb_det;
        logic [39:0] r0;
        logic [24:0] r1;
        logic signed [15:0] lb_s1;
        logic signed [16:0] lb_d1;
        logic [31:0] ctrl;
        logic [31:0] sharp;
        logic [31:0] fb_lo;
        logic [31:0] fb_hi;
        logic prev_swb;
        logic [3:0] prev_core;
        logic [1:0] cls;
        logic [1:0] prev_cls;
        logic hb_flag;
        logic lb_flag;
        logic tilt_hi;
        logic [3:0] fb_q;
        logic [3:0] n_spec;
        logic [2:0] n_time;
        logic [BTC_DELAY*20-1:0] dly;
        logic signed [19:0] mdct_sample;
        logic mdct_valid;
        logic [8:0] mdct_pos;
        logic shb_ready;
        logic lb_ready;
        logic frame_done;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } btc_regs_t;

    btc_regs_t r;
    btc_regs_t next_r;

    logic signed [16:0] xd;
    logic signed [37:0] hp_acc;
    logic signed [19:0] hp_new;
    logic [39:0] sq;
    logic [47:0] e_full;
    logic [47:0] lt_prev;
    logic [55:0] thr;
    logic [31:0] lb_sq;
    logic [47:0] elf_full;
    logic signed [16:0] lb_d;
    logic [16:0] lb_abs;
    logic trans;
    logic [49:0] r1_sq;
    logic [5:0] m_hi;
    logic [5:0] m_lo;
    logic [5:0] q_raw;
    logic [1:0] sharp_cls;
    logic [3:0] core_now;

    // Position of the leading one; zero stands for zero energy too
    function automatic logic [5:0] btc_msb(input logic [31:0] v);
        logic [5:0] p;
        p = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                p = 6'(i);
            end
        end
        return p;
    endfunction

    always_comb begin
        next_r = r;
        next_r.frame_done = 1'b0;
        next_r.mdct_valid = 1'b0;
        core_now = r.ctrl[BTC_CTRL_CORE_LSB +: BTC_CTRL_CORE_W];

        // APB: answer prepared in setup, so access completes with no wait
        next_r.pready = psel & ~penable;
        next_r.pslverr = 1'b0;
        next_r.prdata = 32'h0000_0000;
        if (psel && !penable) begin
            case (paddr)
                BTC_CTRL_OFS: next_r.prdata = r.ctrl;
                BTC_SHARP_OFS: next_r.prdata = r.sharp;
                BTC_FB_LO_OFS: next_r.prdata = r.fb_lo;
                BTC_FB_HI_OFS: next_r.prdata = r.fb_hi;
                BTC_STATUS_OFS: begin
                    next_r.prdata[BTC_ST_CLASS_LSB +: 2] = r.cls;
                    next_r.prdata[BTC_ST_HB] = r.hb_flag;
                    next_r.prdata[BTC_ST_LB] = r.lb_flag;
                    next_r.prdata[BTC_ST_HANG] = r.hang;
                    next_r.prdata[BTC_ST_ENVB_LSB +: 5] = BTC_ENV_BITS;
                    next_r.prdata[BTC_ST_NSPEC_LSB +: 4] = r.n_spec;
                    next_r.prdata[BTC_ST_NTIME_LSB +: 3] = r.n_time;
                    next_r.prdata[BTC_ST_FBQ_LSB +: 4] = r.fb_q;
                    next_r.prdata[BTC_ST_BUSY] = (r.st != BTC_IDLE);
                    next_r.prdata[BTC_ST_TILT] = r.tilt_hi;
                    next_r.prdata[BTC_ST_PREV_LSB +: 2] = r.prev_cls;
                    next_r.prdata[BTC_ST_TOTAL_LSB +: 5] = BTC_FRAME_BITS;
                end
                BTC_LTE_OFS: next_r.prdata = r.lt[47:16];
                BTC_TILT_OFS: next_r.prdata = {7'h00, r.r1};
                default: next_r.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && r.pready && pwrite) begin
            case (paddr)
                BTC_CTRL_OFS: next_r.ctrl = pwdata & BTC_CTRL_MASK;
                BTC_SHARP_OFS: next_r.sharp = pwdata;
                BTC_FB_LO_OFS: next_r.fb_lo = pwdata;
                BTC_FB_HI_OFS: next_r.fb_hi = pwdata;
                default: next_r.prdata = 32'h0000_0000;
            endcase
        end

        // High-pass filter; its state survives frame boundaries
        xd = 17'(super_high_band) - 17'(r.hp_x);
        hp_acc = 38'(BTC_HP_POLE) * 38'(r.hp_y) + 38'(BTC_HP_GAIN) * 38'(xd);
        hp_new = hp_acc[BTC_COEF_FRAC +: 20];
        sq = 40'(40'(hp_new) * 40'(hp_new));
        e_full = r.e_acc + 48'(sq);
        lt_prev = (r.lt_reset && r.shb_cnt < 9'(BTC_SUB_LEN)) ? e_full : r.lt;
        thr = r.ctrl[BTC_CTRL_INACTIVE] ? BTC_RHO_INACTIVE_X2 : BTC_RHO_ACTIVE_X2;

        if (shb_valid && r.shb_ready) begin
            next_r.hp_x = super_high_band;
            next_r.hp_y = hp_new;
            // Delay line aligns the extension path to the core delay
            next_r.dly = {r.dly[(BTC_DELAY-1)*20-1:0], hp_new};
            next_r.mdct_sample = r.dly[BTC_DELAY*20-1 -: 20];
            next_r.mdct_valid = 1'b1;
            next_r.mdct_pos = r.shb_cnt;
            next_r.shb_cnt = r.shb_cnt + 9'h001;
            next_r.shb_ready = (r.shb_cnt != BTC_FRAME_LEN - 9'h001);
            if (r.sub_pos == BTC_SUB_LEN - 7'h01) begin
                next_r.sub_pos = 7'h00;
                next_r.e_acc = 48'h0;
                if (({8'h00, e_full} << 1) > 56'(lt_prev) * thr && r.prev_swb
                    && !r.ctrl[BTC_CTRL_WB]) begin
                    next_r.det = 1'b1;
                end
                next_r.lt = lt_prev - (lt_prev >> BTC_LT_SHIFT)
                    + (e_full >> BTC_LT_SHIFT);
            end else begin
                next_r.sub_pos = r.sub_pos + 7'h01;
                next_r.e_acc = e_full;
            end
        end

        // Low band: sub-frame energies, r0 and sign-change sum
        lb_sq = 32'(32'(low_band) * 32'(low_band));
        elf_full = r.elf_acc + 48'(lb_sq);
        lb_d = 17'(low_band) - 17'(r.lb_s1);
        lb_abs = lb_d[16] ? 17'(-lb_d) : 17'(lb_d);
        if (lb_valid && r.lb_ready) begin
            next_r.lb_s1 = low_band;
            next_r.lb_d1 = lb_d;
            next_r.r0 = r.r0 + 40'(lb_sq);
            if (r.lb_cnt == 9'h001) begin
                next_r.r1 = 25'(lb_abs);
            end else if (r.lb_cnt > 9'h001 && lb_d != 17'sh0 && r.lb_d1 != 17'sh0
                         && (lb_d[16] != r.lb_d1[16])) begin
                next_r.r1 = r.r1 + 25'(lb_abs);
            end
            next_r.lb_cnt = r.lb_cnt + 9'h001;
            next_r.lb_ready = (r.lb_cnt != BTC_LB_LEN - 9'h001);
            if (r.lb_cnt[5:0] == BTC_LB_SUB_LAST) begin
                // First sub-frame compares against last frame's final sub-frame
                if ({elf_full, 1'b0} > {1'b0, r.elf_prev} * BTC_LB_RATIO_X2) begin
                    next_r.lb_det = 1'b1;
                end
                next_r.elf_prev = elf_full;
                next_r.elf_acc = 48'h0;
            end else begin
                next_r.elf_acc = elf_full;
            end
        end

        // Decision terms
        r1_sq = 50'(r.r1) * 50'(r.r1);
        trans = (r.det | r.hang) & !r.ctrl[BTC_CTRL_WB];
        if (r.sharp[BTC_SHARP_VAL_LSB +: 8] > r.sharp[BTC_SHARP_HI_LSB +: 8]) begin
            sharp_cls = BTC_HARMONIC_CLASS;
        end else if (r.sharp[BTC_SHARP_VAL_LSB +: 8] < r.sharp[BTC_SHARP_LO_LSB +: 8]) begin
            sharp_cls = BTC_NOISE_CLASS;
        end else begin
            sharp_cls = BTC_NORMAL_CLASS;
        end
        m_hi = btc_msb(r.fb_hi);
        m_lo = btc_msb(r.fb_lo);
        // Ratio of square roots in log2 is half the leading-one distance
        q_raw = (m_hi > m_lo) ? ((m_hi - m_lo) >> 1) : 6'h00;

        case (r.st)
            BTC_IDLE: begin
                if (frame_start) begin
                    next_r.st = BTC_COLLECT;
                    next_r.shb_cnt = 9'h000;
                    next_r.sub_pos = 7'h00;
                    next_r.lb_cnt = 9'h000;
                    next_r.e_acc = 48'h0;
                    next_r.elf_acc = 48'h0;
                    next_r.det = 1'b0;
                    next_r.lb_det = 1'b0;
                    next_r.r0 = 40'h0;
                    next_r.r1 = 25'h0;
                    next_r.shb_ready = 1'b1;
                    next_r.lb_ready = 1'b1;
                    next_r.lt_reset = (r.ctrl[BTC_CTRL_SWB] != r.prev_swb)
                        || (core_now != r.prev_core);
                end
            end
            BTC_COLLECT: begin
                if (r.shb_cnt == BTC_FRAME_LEN && r.lb_cnt == BTC_LB_LEN) begin
                    next_r.st = BTC_DECIDE;
                end
            end
            BTC_DECIDE: begin
                next_r.st = BTC_IDLE;
                next_r.frame_done = 1'b1;
                next_r.tilt_hi = r1_sq > (50'(r.r0) << BTC_TILT_SHIFT);
                if (trans && r1_sq > (50'(r.r0) << BTC_TILT_SHIFT)) begin
                    trans = 1'b0;
                    next_r.hang = 1'b0;
                end else begin
                    next_r.hang = r.det;
                end
                next_r.hb_flag = trans;
                next_r.lb_flag = r.lb_det;
                next_r.cls = trans ? BTC_TRANSIENT_CLASS : sharp_cls;
                next_r.prev_cls = r.cls;
                next_r.n_spec = trans ? BTC_SPEC_TRANS : BTC_SPEC_STEADY;
                next_r.n_time = (trans && !r.ctrl[BTC_CTRL_WB]) ?
                    BTC_TIME_TRANS : BTC_TIME_NONE;
                next_r.fb_q = !r.ctrl[BTC_CTRL_FB] ? 4'h0 :
                    (q_raw > 6'(BTC_FBQ_MAX)) ? BTC_FBQ_MAX : q_raw[3:0];
                next_r.prev_swb = r.ctrl[BTC_CTRL_SWB];
                next_r.prev_core = core_now;
            end
            default: next_r.st = BTC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.st <= BTC_IDLE;
            r.ctrl <= BTC_CTRL_RESET;
            r.sharp <= BTC_SHARP_RESET;
            r.cls <= BTC_NORMAL_CLASS;
            r.prev_cls <= BTC_NORMAL_CLASS;
            r.n_spec <= BTC_SPEC_STEADY;
            r.n_time <= BTC_TIME_NONE;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign shb_ready = r.shb_ready;
    assign lb_ready = r.lb_ready;
    assign mdct_sample = r.mdct_sample;
    assign mdct_valid = r.mdct_valid;
    assign mdct_pos = r.mdct_pos;
    assign frame_done = r.frame_done;
    assign signal_class = r.cls;
    assign high_band_transient_flag = r.hb_flag;
    assign low_band_transient_flag = r.lb_flag;
    assign spectral_env_count = r.n_spec;
    assign time_env_count = r.n_time;
    assign fb_ratio_index = r.fb_q;
endmodule // btc_transient_classifier

// file: btc_chk.sv
// Port checker for the transient classifier, bound to the design top
module btc_chk
    import btc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic shb_valid,
    input wire logic shb_ready,
    input wire logic lb_ready,
    input wire logic mdct_valid,
    input wire logic frame_done,
    input wire logic [1:0] signal_class,
    input wire logic high_band_transient_flag,
    input wire logic [3:0] spectral_env_count,
    input wire logic [2:0] time_env_count
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= shb_valid && shb_ready;
        end
    end
    property p_pready; psel && !penable |=> pready; endproperty
    property p_slverr; psel && !penable && paddr > BTC_TILT_OFS |=> pslverr; endproperty
    property p_mdct; mdct_valid == acc_q; endproperty
    property p_trans;
        frame_done && signal_class == BTC_TRANSIENT_CLASS
            |-> spectral_env_count == 4'h4 && time_env_count == 3'h4;
    endproperty
    property p_steady;
        frame_done && signal_class != BTC_TRANSIENT_CLASS
            |-> spectral_env_count == 4'hE && time_env_count == 3'h0;
    endproperty
    property p_hb; frame_done && high_band_transient_flag |-> signal_class == 2'h1; endproperty
    property p_hold;
        !frame_done |-> $stable(signal_class) && $stable(high_band_transient_flag);
    endproperty
    property p_idle; frame_done |-> !shb_ready && !lb_ready ##1 !frame_done; endproperty
    // The high-band ready may only fall after a sample has been taken
    property p_rdy; shb_ready && !shb_valid |=> shb_ready; endproperty
    a_pready: assert property (p_pready) else $error("pready missing after setup");
    a_slverr: assert property (p_slverr) else $error("no error on unmapped address");
    a_mdct: assert property (p_mdct) else $error("transform sample not tied to input");
    a_trans: assert property (p_trans) else $error("transient envelope counts wrong");
    a_steady: assert property (p_steady) else $error("steady envelope counts wrong");
    a_hb: assert property (p_hb) else $error("flagged frame not in transient class");
    a_hold: assert property (p_hold) else $error("decision changed between frames");
    a_idle: assert property (p_idle) else $error("stream open at decision");
    a_rdy: assert property (p_rdy) else $error("ready dropped without a sample");
    c_trans: cover property (frame_done && signal_class == BTC_TRANSIENT_CLASS);
    c_harm: cover property (frame_done && signal_class == BTC_HARMONIC_CLASS);
    c_err: cover property (pslverr);
    c_stall: cover property (shb_ready && !shb_valid);
endmodule // btc_chk

bind btc_transient_classifier btc_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .shb_valid(shb_valid), .shb_ready(shb_ready), .lb_ready(lb_ready),
    .mdct_valid(mdct_valid), .frame_done(frame_done), .signal_class(signal_class),
    .high_band_transient_flag(high_band_transient_flag),
    .spectral_env_count(spectral_env_count), .time_env_count(time_env_count));

// file: btc_core_src.sv
// Sample source standing in for the core encoder upstream of the classifier
module btc_core_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [1:0] shape,
    input wire logic slow,
    output logic frame_start,
    output logic signed [15:0] super_high_band,
    output logic shb_valid,
    input wire logic shb_ready,
    output logic signed [15:0] low_band,
    output logic lb_valid,
    input wire logic lb_ready
);
    logic [8:0] ns;
    logic [8:0] nl;
    logic sa, la, sv_n, lv_n;
    // Shape 1 bursts in the last sub-frame; shape 2 also makes the low band rough
    function automatic logic signed [15:0] hb_val(input logic [8:0] i, input logic [1:0] s);
        hb_val = (s != 2'h0 && i >= 9'h0F0) ? 16'sh1F40 : 16'sh0064;
        if (!i[0]) hb_val = -hb_val;
    endfunction
    function automatic logic signed [15:0] lo_val(input logic [8:0] i, input logic [1:0] s);
        lo_val = (s == 2'h1 && i >= 9'h0C0) ? 16'sh0640 : 16'sh00C8;
        if (s == 2'h2 && i[0]) lo_val = -lo_val;
    endfunction
    assign sa = shb_valid && shb_ready;
    assign la = lb_valid && lb_ready;
    assign sv_n = !go && ns + 9'(sa) < 9'h140 && !(slow && sa);
    assign lv_n = !go && nl + 9'(la) < 9'h100 && !(slow && la);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_start <= 1'b0;
            ns <= 9'h140;
            nl <= 9'h100;
            shb_valid <= 1'b0;
            lb_valid <= 1'b0;
            super_high_band <= 16'sh0000;
            low_band <= 16'sh0000;
        end else begin
            frame_start <= go;
            ns <= go ? 9'h000 : ns + 9'(sa);
            nl <= go ? 9'h000 : nl + 9'(la);
            shb_valid <= sv_n;
            lb_valid <= lv_n;
            // Idle lines toggle so a stale value is never mistaken for data
            super_high_band <= sv_n ? hb_val(ns + 9'(sa), shape) : ~super_high_band;
            low_band <= lv_n ? lo_val(nl + 9'(la), shape) : ~low_band;
        end
    end
endmodule // btc_core_src

// file: btc_transient_classifier_tb_top.sv
// Self-checking bench for the transient classifier front end
module btc_transient_classifier_tb_top import btc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] sharp;
        logic [1:0] shape;
        logic slow;
        logic [1:0] cls;
        logic hb;
        logic lb;
        logic [1:0] chk;
        logic [3:0] fbq;
    } btc_row_t;
    localparam btc_row_t ROWS [12] = '{
        '{8'h01, 8'h00, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h1, 4'h0},
        '{8'h01, 8'h08, 2'h0, 1'b1, 2'h2, 1'b0, 1'b0, 2'h3, 4'h0},
        '{8'h01, 8'h08, 2'h1, 1'b0, 2'h1, 1'b1, 1'b1, 2'h3, 4'h0},
        '{8'h01, 8'h20, 2'h0, 1'b0, 2'h1, 1'b0, 1'b0, 2'h2, 4'h0},
        '{8'h01, 8'h20, 2'h0, 1'b1, 2'h3, 1'b0, 1'b0, 2'h3, 4'h0},
        '{8'h01, 8'h08, 2'h2, 1'b0, 2'h2, 1'b0, 1'b0, 2'h3, 4'h0},
        '{8'h01, 8'h00, 2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h3, 4'h0},
        '{8'h00, 8'h08, 2'h0, 1'b0, 2'h2, 1'b0, 1'b0, 2'h3, 4'h0},
        '{8'h01, 8'h08, 2'h1, 1'b0, 2'h2, 1'b0, 1'b1, 2'h3, 4'h0},
        '{8'h09, 8'h08, 2'h1, 1'b0, 2'h2, 1'b0, 1'b1, 2'h3, 4'h0},
        '{8'h05, 8'h20, 2'h0, 1'b0, 2'h3, 1'b0, 1'b0, 2'h3, 4'h4},
        '{8'h03, 8'h08, 2'h1, 1'b0, 2'h1, 1'b1, 1'b1, 2'h3, 4'h0}
    };
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, go, slow;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0] shape, signal_class;
    logic frame_start, shb_valid, shb_ready, lb_valid, lb_ready, mdct_valid, frame_done;
    logic signed [15:0] super_high_band, low_band;
    logic high_band_transient_flag, low_band_transient_flag, e;
    logic [3:0] spectral_env_count, fb_ratio_index;
    logic [2:0] time_env_count;
    int n_fail = 0;
    int n_tests = 0;
    int n_mdct = 0;
    int cyc = 0;
    btc_row_t r;
    btc_transient_classifier u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_start(frame_start),
        .super_high_band(super_high_band), .shb_valid(shb_valid), .shb_ready(shb_ready),
        .low_band(low_band), .lb_valid(lb_valid), .lb_ready(lb_ready), .mdct_sample(),
        .mdct_valid(mdct_valid), .mdct_pos(), .frame_done(frame_done),
        .signal_class(signal_class), .high_band_transient_flag(high_band_transient_flag),
        .low_band_transient_flag(low_band_transient_flag),
        .spectral_env_count(spectral_env_count), .time_env_count(time_env_count),
        .fb_ratio_index(fb_ratio_index));
    btc_core_src u_src (.pclk(pclk), .presetn(presetn), .go(go), .shape(shape), .slow(slow),
        .frame_start(frame_start), .super_high_band(super_high_band), .shb_valid(shb_valid),
        .shb_ready(shb_ready), .low_band(low_band), .lb_valid(lb_valid), .lb_ready(lb_ready));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (mdct_valid === 1'b1) n_mdct++;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    // Called just after a rising edge; holds the request until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run_frame();
        int k;
        n_mdct = 0;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        k = 0;
        while (frame_done !== 1'b1 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        go = 1'b0;
        shape = 2'h0;
        slow = 1'b0;
        repeat (16) @(posedge pclk);
        chk("class_rst", 32'(signal_class), 32'(BTC_NORMAL_CLASS));
        chk("spec_rst", 32'(spectral_env_count), 32'hE);
        chk("time_rst", 32'(time_env_count), 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, BTC_CTRL_OFS, 32'h0);
        chk("ctrl_rst", q, 32'h0000_0001);
        apb(1'b0, BTC_SHARP_OFS, 32'h0);
        chk("sharp_rst", q, 32'h0004_1000);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped", 32'(e), 32'h1);
        apb(1'b1, BTC_FB_LO_OFS, 32'h1);
        apb(1'b1, BTC_FB_HI_OFS, 32'h100);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            apb(1'b1, BTC_CTRL_OFS, {24'h0, r.ctrl});
            apb(1'b1, BTC_SHARP_OFS, {16'h0004, 8'h10, r.sharp});
            shape <= r.shape;
            slow <= r.slow;
            run_frame();
            chk("class", 32'(signal_class), 32'(r.cls));
            if (r.chk[0]) chk("hb_flag", 32'(high_band_transient_flag), 32'(r.hb));
            if (r.chk[1]) chk("lb_flag", 32'(low_band_transient_flag), 32'(r.lb));
            chk("spec", 32'(spectral_env_count), r.cls == 2'h1 ? 32'h4 : 32'hE);
            chk("time", 32'(time_env_count), r.cls == 2'h1 ? 32'h4 : 32'h0);
            chk("fbq", 32'(fb_ratio_index), 32'(r.fbq));
            chk("mdct_n", 32'(n_mdct), 32'd320);
            apb(1'b0, BTC_STATUS_OFS, 32'h0);
            chk("st_class", 32'(q[1:0]), 32'(r.cls));
            chk("st_env", 32'(q[9:5]), 32'd29);
            chk("st_total", 32'(q[29:25]), 32'd31);
        end
        give_verdict();
    end
endmodule // btc_transient_classifier_tb_top
